/* File: mcupm_pin_mux.sv */
// Pin function multiplexer and external bus strobes of an 8-bit microcontroller
`default_nettype none
module mcupm_pin_mux (
  input  wire logic        clk,
  input  wire logic        arst_n,
  // Wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [31:0] wb_dat_i,
  input  wire logic [3:0]  wb_sel_i,
  output logic             wb_ack_o,
  output logic      [31:0] wb_dat_o,
  // Core external bus request
  input  wire logic        core_req,
  input  wire logic        core_we,
  input  wire logic        core_fetch,
  input  wire logic [15:0] core_addr,
  input  wire logic [7:0]  core_wdata,
  output logic      [7:0]  core_rdata,
  output logic             core_done,
  // Alternate functions of the peripheral port and slave bus
  input  wire logic [7:0]  periph_alt_out,
  input  wire logic [7:0]  periph_alt_oe,
  input  wire logic [7:0]  slave_bus_dout,
  input  wire logic        slave_bus_oe,
  output logic      [4:0]  slave_ctl_in,
  output logic      [2:0]  ext_int,
  // Straps
  input  wire logic        processor_mode_pin,
  input  wire logic        eprom_mode_pin,
  input  wire logic        large_package_pin,
  // EPROM array access
  input  wire logic [7:0]  eprom_rdata,
  output logic      [14:0] eprom_addr,
  output logic      [7:0]  eprom_wdata,
  output logic             eprom_wr,
  // Port pins
  input  wire logic [7:0]  address_low_port_i,
  output logic      [7:0]  address_low_port_o,
  output logic      [7:0]  address_low_port_oe,
  input  wire logic [7:0]  address_high_port_i,
  output logic      [7:0]  address_high_port_o,
  output logic      [7:0]  address_high_port_oe,
  input  wire logic [7:0]  data_bus_port_i,
  output logic      [7:0]  data_bus_port_o,
  output logic      [7:0]  data_bus_port_oe,
  input  wire logic [7:0]  peripheral_port_i,
  output logic      [7:0]  peripheral_port_o,
  output logic      [7:0]  peripheral_port_oe,
  input  wire logic [7:0]  slave_data_port_i,
  output logic      [7:0]  slave_data_port_o,
  output logic      [7:0]  slave_data_port_oe,
  input  wire logic [7:0]  slave_control_port_i,
  output logic      [7:0]  slave_control_port_o,
  output logic      [7:0]  slave_control_port_oe,
  input  wire logic [7:0]  analog_input_port,
  output logic             timing_clk,
  output logic             fetch_flag,
  output logic             rw_dir,
  output logic             rd_n,
  output logic             wr_n,
  output logic             peripheral_reset_drive
);
  logic [7:0] pin_raw [7];
  logic [7:0] pin_s1  [7];
  logic [7:0] pin    [7];
  logic [2:0] strap_s1;
  logic [2:0] strap;
  logic [7:0] port_reg [mcupm_pkg::PORT_NUM];
  logic [7:0] dir_reg  [mcupm_pkg::PORT_NUM];
  logic [7:0] nxt_o    [mcupm_pkg::PORT_NUM];
  logic [7:0] nxt_oe   [mcupm_pkg::PORT_NUM];
  logic [7:0] pin_o    [mcupm_pkg::PORT_NUM];
  logic [7:0] pin_oe   [mcupm_pkg::PORT_NUM];
  logic [1:0] mode;
  logic [7:0] periph_fn;
  logic [3:0] slave_ctl;
  logic [1:0] strap_cnt;
  logic       strap_done;
  logic [1:0] phi_cnt;
  logic [7:0] strb_cnt;
  mcupm_pkg::mcupm_bus_t bus_state;
  logic [15:0] bus_addr;
  logic [7:0]  bus_wdata;
  logic        bus_we;
  logic        bus_fetch;
  logic        wb_hit;
  logic [31:0] next_rdata;
  logic        eprom_mode;
  logic        single_chip;
  logic        slave_en;

  assign pin_raw[mcupm_pkg::P_ADDR_LO] = address_low_port_i;
  assign pin_raw[mcupm_pkg::P_ADDR_HI] = address_high_port_i;
  assign pin_raw[mcupm_pkg::P_DATA]    = data_bus_port_i;
  assign pin_raw[mcupm_pkg::P_PERIPH]  = peripheral_port_i;
  assign pin_raw[mcupm_pkg::P_SLV_DAT] = slave_data_port_i;
  assign pin_raw[mcupm_pkg::P_SLV_CTL] = slave_control_port_i;
  assign pin_raw[mcupm_pkg::P_ANALOG]  = analog_input_port;
  assign eprom_mode  = strap[1];
  assign single_chip = (mode == mcupm_pkg::MODE_SINGLE) && !eprom_mode;
  assign slave_en    = slave_ctl[mcupm_pkg::SLV_EN_BIT];
  assign wb_hit      = wb_cyc_i && wb_stb_i && !wb_ack_o;

  // Two-stage synchronisers for every pin and strap
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      for (int k = 0; k < 7; k++)
      begin
        pin_s1[k] <= 8'h00;
        pin[k]    <= 8'h00;
      end
      strap_s1 <= 3'h0;
      strap    <= 3'h0;
    end
    else
    begin
      for (int k = 0; k < 7; k++)
      begin
        pin_s1[k] <= pin_raw[k];
        pin[k]    <= pin_s1[k];
      end
      strap_s1 <= {large_package_pin, eprom_mode_pin, processor_mode_pin};
      strap    <= strap_s1;
    end
  end

  // reset sequencing after release
  // Strap capture waits for the synchroniser to fill, then ends reset drive
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      strap_cnt  <= 2'h0;
      strap_done <= 1'b0;
    end
    else if (!strap_done)
    begin
      strap_cnt  <= strap_cnt + 2'h1;
      strap_done <= (strap_cnt == 2'(mcupm_pkg::STRAP_WAIT - 1));
    end
  end

  // peripheral reset drive
  // High through reset and strap capture; also held high in EPROM mode
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      peripheral_reset_drive <= 1'b1;
    else
      peripheral_reset_drive <= !strap_done || eprom_mode;
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      phi_cnt    <= 2'h0;
      timing_clk <= 1'b0;
    end
    else
    begin
      phi_cnt    <= phi_cnt + 2'h1;
      timing_clk <= phi_cnt[1];
    end
  end

  // Bus cycle sequencer; a request is taken only in idle outside single-chip mode
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      bus_state <= mcupm_pkg::BUS_IDLE;
      bus_addr  <= 16'h0000;
      bus_wdata <= 8'h00;
      bus_we    <= 1'b0;
      bus_fetch <= 1'b0;
      strb_cnt  <= 8'h00;
      core_rdata <= 8'h00;
      core_done <= 1'b0;
    end
    else
    begin
      core_done <= (bus_state == mcupm_pkg::BUS_STRB) && (strb_cnt == 8'h00);
      unique case (bus_state)
        mcupm_pkg::BUS_IDLE:
          if (core_req && strap_done && !single_chip && !eprom_mode)
          begin
            bus_state <= mcupm_pkg::BUS_ADDR;
            bus_addr  <= core_addr;
            bus_wdata <= core_wdata;
            bus_we    <= core_we;
            bus_fetch <= core_fetch && !core_we;
          end
        mcupm_pkg::BUS_ADDR:
        begin
          bus_state <= mcupm_pkg::BUS_STRB;
          strb_cnt  <= 8'(mcupm_pkg::STRB_CYC - 1);
        end
        mcupm_pkg::BUS_STRB:
          if (strb_cnt == 8'h00)
          begin
            bus_state  <= mcupm_pkg::BUS_DONE;
            core_rdata <= bus_we ? core_rdata : pin[mcupm_pkg::P_DATA];
          end
          else
            strb_cnt <= strb_cnt - 8'h01;
        mcupm_pkg::BUS_DONE:
          bus_state <= mcupm_pkg::BUS_IDLE;
      endcase
    end
  end

  // Bus strobes, registered from the sequencer state
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rw_dir     <= 1'b1;
      rd_n       <= 1'b1;
      wr_n       <= 1'b1;
      fetch_flag <= 1'b0;
    end
    else if (eprom_mode)
    begin
      rw_dir     <= 1'b1;
      rd_n       <= 1'b1;
      wr_n       <= 1'b1;
      fetch_flag <= 1'b0;
    end
    else
    begin
      rw_dir     <= !((bus_state != mcupm_pkg::BUS_IDLE) && bus_we);
      rd_n       <= !((bus_state == mcupm_pkg::BUS_STRB) && !bus_we);
      wr_n       <= !((bus_state == mcupm_pkg::BUS_STRB) && bus_we);
      // fetch flag only for opcode reads
      fetch_flag <= (bus_state != mcupm_pkg::BUS_IDLE) && bus_fetch;
    end
  end

  // Pin drive selection per port
  always_comb
  begin
    for (int k = 0; k < mcupm_pkg::PORT_NUM; k++)
    begin
      nxt_o[k]  = port_reg[k];
      nxt_oe[k] = dir_reg[k];
    end
    for (int b = 0; b < 8; b++)
      if (periph_fn[b])
      begin
        nxt_o[mcupm_pkg::P_PERIPH][b]  = periph_alt_out[b];
        nxt_oe[mcupm_pkg::P_PERIPH][b] = periph_alt_oe[b];
      end
    if (slave_en)
    begin
      nxt_o[mcupm_pkg::P_SLV_DAT]  = slave_bus_dout;
      nxt_oe[mcupm_pkg::P_SLV_DAT] = {8{slave_bus_oe}};
      nxt_oe[mcupm_pkg::P_SLV_CTL][7:mcupm_pkg::SLV_BUS_LSB] = 5'h00;
    end
    if (eprom_mode)
    begin
      // EPROM pins: address in, data out on read
      for (int k = 0; k < mcupm_pkg::PORT_NUM; k++)
        nxt_oe[k] = 8'h00;
      nxt_o[mcupm_pkg::P_DATA]  = eprom_rdata;
      nxt_oe[mcupm_pkg::P_DATA] = {8{!pin[mcupm_pkg::P_SLV_DAT][mcupm_pkg::EP_CE_PIN]
                                    && !pin[mcupm_pkg::P_SLV_DAT][mcupm_pkg::EP_OE_PIN]}};
    end
    else if (!single_chip)
    begin
      nxt_o[mcupm_pkg::P_ADDR_LO]  = bus_addr[7:0];
      nxt_oe[mcupm_pkg::P_ADDR_LO] = 8'hFF;
      nxt_o[mcupm_pkg::P_ADDR_HI]  = bus_addr[15:8];
      nxt_oe[mcupm_pkg::P_ADDR_HI] = 8'hFF;
      // data port driven only for writes
      nxt_o[mcupm_pkg::P_DATA]  = bus_wdata;
      nxt_oe[mcupm_pkg::P_DATA] = {8{(bus_state != mcupm_pkg::BUS_IDLE) && bus_we}};
    end
  end

  // Registered pin outputs; in single-chip mode port, direction, periph_fn and slave_ctl registers steer them
  // plain I/O in single-chip mode
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      for (int k = 0; k < mcupm_pkg::PORT_NUM; k++)
      begin
        pin_o[k]  <= 8'h00;
        pin_oe[k] <= 8'h00;
      end
    else
      for (int k = 0; k < mcupm_pkg::PORT_NUM; k++)
      begin
        pin_o[k]  <= nxt_o[k];
        pin_oe[k] <= nxt_oe[k];
      end
  end

  assign address_low_port_o    = pin_o[mcupm_pkg::P_ADDR_LO];
  assign address_low_port_oe   = pin_oe[mcupm_pkg::P_ADDR_LO];
  assign address_high_port_o   = pin_o[mcupm_pkg::P_ADDR_HI];
  assign address_high_port_oe  = pin_oe[mcupm_pkg::P_ADDR_HI];
  assign data_bus_port_o       = pin_o[mcupm_pkg::P_DATA];
  assign data_bus_port_oe      = pin_oe[mcupm_pkg::P_DATA];
  assign peripheral_port_o     = pin_o[mcupm_pkg::P_PERIPH];
  assign peripheral_port_oe    = pin_oe[mcupm_pkg::P_PERIPH];
  assign slave_data_port_o     = pin_o[mcupm_pkg::P_SLV_DAT];
  assign slave_data_port_oe    = pin_oe[mcupm_pkg::P_SLV_DAT];
  assign slave_control_port_o  = pin_o[mcupm_pkg::P_SLV_CTL];
  assign slave_control_port_oe = pin_oe[mcupm_pkg::P_SLV_CTL];

  // Slave control inputs, enabled interrupt pins and EPROM address capture
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      slave_ctl_in <= 5'h00;
      ext_int      <= 3'h0;
      eprom_addr   <= 15'h0000;
      eprom_wdata  <= 8'h00;
      eprom_wr     <= 1'b0;
    end
    else
    begin
      // master control bus and interrupt pins
      slave_ctl_in <= slave_en ? pin[mcupm_pkg::P_SLV_CTL][7:mcupm_pkg::SLV_BUS_LSB] : 5'h00;
      ext_int      <= pin[mcupm_pkg::P_SLV_CTL][mcupm_pkg::SLV_INT_PINS-1:0]
                      & slave_ctl[mcupm_pkg::SLV_INT_MSB:mcupm_pkg::SLV_INT_LSB];
      // 8 + 6 address bits plus A14
      eprom_addr   <= {pin[mcupm_pkg::P_SLV_DAT][mcupm_pkg::EP_A14_PIN],
                       pin[mcupm_pkg::P_ADDR_HI][mcupm_pkg::EP_HI_BITS-1:0],
                       pin[mcupm_pkg::P_ADDR_LO]};
      eprom_wdata  <= pin[mcupm_pkg::P_DATA];
      eprom_wr     <= eprom_mode && !pin[mcupm_pkg::P_SLV_DAT][mcupm_pkg::EP_CE_PIN]
                      && pin[mcupm_pkg::P_SLV_DAT][mcupm_pkg::EP_OE_PIN];
    end
  end

  // Register file writes; byte lane 0 carries all 8-bit registers
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      for (int k = 0; k < mcupm_pkg::PORT_NUM; k++)
      begin
        port_reg[k] <= mcupm_pkg::PORT_RST;
        dir_reg[k]  <= mcupm_pkg::DIR_RST;
      end
      mode      <= mcupm_pkg::MODE_SINGLE;
      periph_fn <= 8'h00;
      slave_ctl <= 4'h0;
    end
    else
    begin
      // mode pin sampled once after reset
      if (!strap_done && strap_cnt == 2'(mcupm_pkg::STRAP_WAIT - 1))
        mode <= strap[0] ? mcupm_pkg::MODE_EXPAND : mcupm_pkg::MODE_SINGLE;
      else if (wb_hit && wb_we_i && wb_sel_i[0])
      begin
        for (int k = 0; k < mcupm_pkg::PORT_NUM; k++)
        begin
          if (wb_adr_i == 8'(mcupm_pkg::OFS_PORT_BASE + k * mcupm_pkg::OFS_PORT_STEP))
            port_reg[k] <= wb_dat_i[7:0];
          if (wb_adr_i == 8'(mcupm_pkg::OFS_PORT_BASE + k * mcupm_pkg::OFS_PORT_STEP
                             + mcupm_pkg::OFS_DIR_DELTA))
            dir_reg[k] <= wb_dat_i[7:0];
        end
        if (wb_adr_i == mcupm_pkg::OFS_MISC_MODE)
          mode <= wb_dat_i[mcupm_pkg::MODE_MSB:mcupm_pkg::MODE_LSB];
        if (wb_adr_i == mcupm_pkg::OFS_PERIPH_FN)
          periph_fn <= wb_dat_i[7:0];
        if (wb_adr_i == mcupm_pkg::OFS_SLAVE_CTL)
          slave_ctl <= wb_dat_i[3:0];
      end
    end
  end

  // Read mux; unmapped addresses read zero
  always_comb
  begin
    next_rdata = 32'h0000_0000;
    for (int k = 0; k < mcupm_pkg::PORT_NUM; k++)
    begin
      if (wb_adr_i == 8'(mcupm_pkg::OFS_PORT_BASE + k * mcupm_pkg::OFS_PORT_STEP))
        next_rdata[7:0] = (port_reg[k] & dir_reg[k]) | (pin[k] & ~dir_reg[k]);
      if (wb_adr_i == 8'(mcupm_pkg::OFS_PORT_BASE + k * mcupm_pkg::OFS_PORT_STEP
                         + mcupm_pkg::OFS_DIR_DELTA))
        next_rdata[7:0] = dir_reg[k];
    end
    if (wb_adr_i == mcupm_pkg::OFS_ANALOG)
      next_rdata[7:0] = pin[mcupm_pkg::P_ANALOG] & (strap[2] ? mcupm_pkg::ANALOG_MASK_LARGE
                                                            : mcupm_pkg::ANALOG_MASK_SMALL);
    if (wb_adr_i == mcupm_pkg::OFS_MISC_MODE)
      next_rdata[1:0] = mode;
    if (wb_adr_i == mcupm_pkg::OFS_PERIPH_FN)
      next_rdata[7:0] = periph_fn;
    if (wb_adr_i == mcupm_pkg::OFS_SLAVE_CTL)
      next_rdata[3:0] = slave_ctl;
    if (wb_adr_i == mcupm_pkg::OFS_STATUS)
      next_rdata[4:0] = {bus_state != mcupm_pkg::BUS_IDLE, strap_done, strap};
  end

  // Single-wait-state Wishbone answer
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end
    else
    begin
      wb_ack_o <= wb_hit;
      wb_dat_o <= wb_hit ? next_rdata : 32'h0000_0000;
    end
  end

  // Period of four clocks, two high and two low, judged from the pin alone
  a_phi_divide: assert property (@(posedge clk) disable iff (!arst_n)
    $rose(timing_clk) |-> ##1 timing_clk ##1 !timing_clk ##1 !timing_clk ##1 timing_clk)
    else $error("timing clock wrong");
  a_fetch_read: assert property (@(posedge clk) disable iff (!arst_n)
    fetch_flag |-> rw_dir) else $error("fetch flag during write");
  a_write_dir: assert property (@(posedge clk) disable iff (!arst_n)
    !wr_n |-> !rw_dir) else $error("write strobe with read direction");
  a_rd_wr_excl: assert property (@(posedge clk) disable iff (!arst_n)
    !(!rd_n && !wr_n)) else $error("both strobes low");
  a_strobe_width: assert property (@(posedge clk) disable iff (!arst_n)
    $fell(wr_n) |-> !wr_n [*4] ##1 wr_n) else $error("write strobe width");
  a_eprom_levels: assert property (@(posedge clk) disable iff (!arst_n)
    $past(eprom_mode) && eprom_mode |-> rd_n && wr_n && rw_dir && !fetch_flag
    && peripheral_reset_drive) else $error("EPROM output levels");
  a_single_addr: assert property (@(posedge clk) disable iff (!arst_n)
    $past(single_chip) |-> address_low_port_oe == $past(dir_reg[0])) else $error("addr port");
  a_expand_addr: assert property (@(posedge clk) disable iff (!arst_n)
    $past(!single_chip && !eprom_mode) |-> address_low_port_oe == 8'hFF
    && address_high_port_o == $past(bus_addr[15:8])) else $error("address not driven");
  a_reset_drive: assert property (@(posedge clk) disable iff (!arst_n)
    $past(!strap_done) |-> peripheral_reset_drive) else $error("reset drive dropped early");
  a_done_pulse: assert property (@(posedge clk) disable iff (!arst_n)
    core_done |-> ##1 !core_done) else $error("done longer than one cycle");
endmodule : mcupm_pin_mux
`default_nettype wire

/* File: mcupm_pkg.sv */
// Package: register map, field positions, reset values and timing counts for the pin mux
`default_nettype none
package mcupm_pkg;
  // Port indices into the per-port arrays
  localparam int PORT_NUM  = 6;
  localparam int P_ADDR_LO = 0;
  localparam int P_ADDR_HI = 1;
  localparam int P_DATA    = 2;
  localparam int P_PERIPH  = 3;
  localparam int P_SLV_DAT = 4;
  localparam int P_SLV_CTL = 5;
  localparam int P_ANALOG  = 6;
  // Register byte offsets; port k data at 8k, direction at 8k+4
  localparam logic [7:0] OFS_PORT_BASE  = 8'h00;
  localparam logic [7:0] OFS_PORT_STEP  = 8'h08;
  localparam logic [7:0] OFS_DIR_DELTA  = 8'h04;
  localparam logic [7:0] OFS_ANALOG     = 8'h30;
  localparam logic [7:0] OFS_MISC_MODE  = 8'h34;
  localparam logic [7:0] OFS_PERIPH_FN  = 8'h38;
  localparam logic [7:0] OFS_SLAVE_CTL  = 8'h3C;
  localparam logic [7:0] OFS_STATUS     = 8'h40;
  // Processor mode field of the misc mode register
  localparam int MODE_LSB = 0;
  localparam int MODE_MSB = 1;
  localparam logic [1:0] MODE_SINGLE = 2'h0;
  localparam logic [1:0] MODE_EXPAND = 2'h2;
  // Slave control register fields
  localparam int SLV_EN_BIT  = 0;
  localparam int SLV_INT_LSB = 1;
  localparam int SLV_INT_MSB = 3;
  // Slave control pins: 3..7 bus, 0..2 interrupt
  localparam int SLV_BUS_LSB = 3;
  localparam int SLV_INT_PINS = 3;
  // EPROM mode pin use on the slave data port
  localparam int EP_A14_PIN = 0;
  localparam int EP_OE_PIN  = 1;
  localparam int EP_CE_PIN  = 2;
  localparam int EP_HI_BITS = 6;
  // Reset values
  localparam logic [7:0] PORT_RST = 8'h00;
  localparam logic [7:0] DIR_RST  = 8'h00;
  // Analog port width per package
  localparam logic [7:0] ANALOG_MASK_SMALL = 8'h07;
  localparam logic [7:0] ANALOG_MASK_LARGE = 8'hFF;
  // Timing: clock 250 MHz, strobe width 16 ns
  localparam int CLK_MHZ       = 250;
  localparam int STRB_NS       = 16;
  localparam int STRB_CYC      = (STRB_NS * CLK_MHZ + 999) / 1000;
  localparam int PHI_DIV       = 4;
  localparam int RST_MIN_CYC   = 8;
  localparam int STRAP_WAIT    = 3;
  // Bus cycle states
  typedef enum logic [1:0] {BUS_IDLE, BUS_ADDR, BUS_STRB, BUS_DONE} mcupm_bus_t;
endpackage : mcupm_pkg
`default_nettype wire

/* File: mcupm_ext_mem.sv */
// External memory model on the expanded data bus
`default_nettype none
module mcupm_ext_mem (
  input  wire logic       clk,
  input  wire logic       rd_n,
  input  wire logic       wr_n,
  input  wire logic [7:0] adr,
  input  wire logic [7:0] din,
  output logic      [7:0] dout
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] mem [256];
  logic [7:0] last = 8'h00;
  logic       wr_q = 1'b1;
  // Data only under the read strobe, a changed value otherwise
  assign dout = rd_n ? ~last : mem[adr];
  // Byte stored as the write strobe ends
  always @(posedge clk)
  begin
    wr_q <= wr_n;
    if (!rd_n)
      last <= mem[adr];
    if (wr_n && !wr_q)
      mem[adr] <= din;
  end
endmodule : mcupm_ext_mem
`default_nettype wire

/* File: mcupm_pin_mux_tb_top.sv */
// Self-checking bench for the pin mux
`default_nettype none
module mcupm_pin_mux_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clk = 1'b0, arst_n = 1'b0, wb_cyc_i = 1'b0, wb_we_i = 1'b0, core_req = 1'b0;
  logic        core_we = 1'b0, core_fetch = 1'b0, slave_bus_oe = 1'b0, eprom_mode_pin = 1'b0;
  logic [7:0]  wb_adr_i = 8'h00, core_wdata = 8'h00, periph_alt_out = 8'h00;
  logic [7:0]  periph_alt_oe = 8'h00, slave_bus_dout = 8'h00, address_low_port_i = 8'h00;
  logic [7:0]  address_high_port_i = 8'h00, slave_data_port_i = 8'h00;
  logic [7:0]  slave_control_port_i = 8'h00, analog_input_port = 8'hFF;
  logic [31:0] wb_dat_i = 32'h0000_0000, wb_dat_o;
  logic [15:0] core_addr = 16'h0000;
  logic        wb_ack_o, core_done, timing_clk, fetch_flag, rw_dir, rd_n, wr_n;
  logic        peripheral_reset_drive;
  logic        eprom_wr, processor_mode_pin = 1'b0, large_package_pin = 1'b0;
  logic [2:0]  ext_int;
  logic [7:0]  core_rdata, address_low_port_o, address_low_port_oe, address_high_port_o;
  logic [7:0]  address_high_port_oe, data_bus_port_i, data_bus_port_o, data_bus_port_oe;
  logic [7:0]  peripheral_port_o, peripheral_port_oe, slave_data_port_o, slave_data_port_oe;
  logic [7:0]  mem_d, slave_control_port_oe;
  logic [4:0]  slave_ctl_in;
  logic [14:0] eprom_addr;
  int          err_total = 0, n_checks = 0;

  mcupm_pin_mux uut (
    .clk, .arst_n, .wb_cyc_i, .wb_stb_i(wb_cyc_i), .wb_we_i, .wb_adr_i, .wb_dat_i,
    .wb_sel_i(4'h1), .wb_ack_o, .wb_dat_o, .core_req, .core_we, .core_fetch, .core_addr,
    .core_wdata, .core_rdata, .core_done, .periph_alt_out, .periph_alt_oe, .slave_bus_dout,
    .slave_bus_oe, .slave_ctl_in, .ext_int, .processor_mode_pin, .eprom_mode_pin,
    .large_package_pin, .eprom_rdata(8'h96), .eprom_addr, .eprom_wdata(),
    .eprom_wr, .address_low_port_i, .address_low_port_o, .address_low_port_oe,
    .address_high_port_i, .address_high_port_o, .address_high_port_oe, .data_bus_port_i,
    .data_bus_port_o, .data_bus_port_oe, .peripheral_port_i(8'h00), .peripheral_port_o,
    .peripheral_port_oe, .slave_data_port_i, .slave_data_port_o, .slave_data_port_oe,
    .slave_control_port_i, .slave_control_port_o(), .slave_control_port_oe,
    .analog_input_port, .timing_clk, .fetch_flag, .rw_dir, .rd_n, .wr_n,
    .peripheral_reset_drive
  );
  mcupm_ext_mem mem_u (
    .clk, .rd_n, .wr_n, .adr(address_low_port_o), .din(data_bus_port_o), .dout(mem_d)
  );
  // Data wire level: design where enabled, memory elsewhere
  assign data_bus_port_i = (data_bus_port_o & data_bus_port_oe) | (mem_d & ~data_bus_port_oe);
  // 4 ns clock
  always #2 clk = ~clk;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic test_done;
    $display("checks=%0d errors=%0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : test_done

  // Classic single cycle; entered just after a rising edge
  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d,
                    output logic [7:0] q);
    wb_cyc_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= {24'h00_0000, d};
    do @(posedge clk); while (wb_ack_o !== 1'b1);
    q = wb_dat_o[7:0];
    wb_cyc_i <= 1'b0;
    @(posedge clk);
  endtask : wb

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    wb(1'b1, a, d, q);
  endtask : wr

  task automatic rc(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] q;
    wb(1'b0, a, 8'h00, q);
    chk(q, e);
  endtask : rc

  // One external bus cycle; request dropped once taken, strobes judged each cycle
  task automatic bus(input logic w, input logic f, input logic [15:0] a, input logic [7:0] d);
    int n;
    n = 0;
    core_req <= 1'b1;
    core_we <= w;
    core_fetch <= f;
    core_addr <= a;
    core_wdata <= d;
    @(posedge clk);
    core_req <= 1'b0;
    do
    begin
      @(posedge clk);
      if ((w ? wr_n : rd_n) === 1'b0)
      begin
        n++;
        chk(rw_dir, !w);
        chk(fetch_flag, f);
        chk({address_high_port_oe, address_low_port_oe, address_high_port_o,
             address_low_port_o}, {16'hFFFF, a});
        chk(data_bus_port_oe, {8{w}});
        if (w)
          chk(data_bus_port_o, d);
      end
    end while (core_done !== 1'b1);
    chk(n, mcupm_pkg::STRB_CYC);
  endtask : bus

  task automatic t_clk;
    int   t;
    logic p;
    t = 0;
    p = timing_clk;
    repeat (16)
    begin
      @(posedge clk);
      t += int'(timing_clk !== p);
      p = timing_clk;
    end
    chk(t, 8);
  endtask : t_clk

  task automatic t_ports;
    wr(8'h04, 8'h0F);
    wr(8'h00, 8'h3C);
    wr(8'h38, 8'hF0);
    address_low_port_i <= 8'hA5;
    periph_alt_out <= 8'hA5;
    periph_alt_oe <= 8'hFF;
    repeat (5) @(posedge clk);
    chk({address_low_port_oe, address_low_port_o & 8'h0F}, 16'h0F0C);
    rc(8'h00, 8'hAC);
    chk({peripheral_port_oe, peripheral_port_o & 8'hF0}, 16'hF0A0);
    rc(8'h30, 8'h07);
    rc(8'h34, 8'h00);
    rc(8'h50, 8'h00);
    chk({rd_n, wr_n}, 2'h3);
  endtask : t_ports

  task automatic t_bus;
    wr(8'h34, 8'h02);
    rc(8'h34, 8'h02);
    bus(1'b1, 1'b0, 16'h12A5, 8'h3C);
    bus(1'b0, 1'b1, 16'h12A5, 8'h00);
    chk(core_rdata, 8'h3C);
    // Fetch flag still stands one cycle past the closing cycle, so look two edges later
    repeat (2) @(posedge clk);
    chk({fetch_flag, rw_dir}, 2'h1);
  endtask : t_bus

  task automatic t_slave;
    wr(8'h2C, 8'hFF);
    wr(8'h3C, 8'h0B);
    slave_bus_dout <= 8'hC3;
    slave_bus_oe <= 1'b1;
    slave_control_port_i <= 8'hAF;
    repeat (5) @(posedge clk);
    chk({slave_data_port_oe, slave_data_port_o}, 16'hFFC3);
    chk(slave_ctl_in, 5'h15);
    chk(ext_int, 3'h5);
    chk(slave_control_port_oe, 8'h07);
  endtask : t_slave

  task automatic t_eprom;
    eprom_mode_pin <= 1'b1;
    address_low_port_i <= 8'h5A;
    address_high_port_i <= 8'hC7;
    slave_data_port_i <= 8'h01;
    repeat (6) @(posedge clk);
    chk(eprom_addr, 15'h475A);
    chk({fetch_flag, rw_dir, rd_n, wr_n, peripheral_reset_drive}, 5'h0F);
    chk({data_bus_port_oe, data_bus_port_o}, 16'hFF96);
    slave_data_port_i <= 8'h03;
    repeat (4) @(posedge clk);
    chk(eprom_wr, 1'b1);
  endtask : t_eprom

  // Second reset in mid-run with mode and package straps high
  task automatic t_strap;
    eprom_mode_pin <= 1'b0;
    processor_mode_pin <= 1'b1;
    large_package_pin <= 1'b1;
    arst_n <= 1'b0;
    repeat (10) @(posedge clk);
    chk(peripheral_reset_drive, 1'b1);
    arst_n <= 1'b1;
    repeat (6) @(posedge clk);
    rc(8'h34, 8'h02);
    rc(8'h40, 8'h0D);
    rc(8'h30, 8'hFF);
  endtask : t_strap

  // Main sequence
  initial
  begin
    repeat (10) @(posedge clk);
    chk({peripheral_reset_drive, rd_n, wr_n, fetch_flag}, 4'hE);
    arst_n <= 1'b1;
    repeat (6) @(posedge clk);
    chk(peripheral_reset_drive, 1'b0);
    t_clk();
    t_ports();
    t_bus();
    t_slave();
    t_eprom();
    t_strap();
    test_done();
  end

  // Hang guard, well above the roughly 126 cycles the run needs
  initial
  begin
    repeat (3000) @(posedge clk);
    err_total++;
    test_done();
  end
endmodule : mcupm_pin_mux_tb_top
`default_nettype wire
